// >>> core/ohlp_list_ptrs.sv
//Contract
//- control current register holds served descriptor address in bits 31:4.
//- after serving a control descriptor, advance current pointer to next.
//- each frame resumes control list at the current pointer, not head.
//- at list end sample filled flag bit 1; clear flag leaves pointer.
//- at list end with flag set, load head into current, clear flag.
//- with list enable set, software only reads; reads give live value.
//- control current starts at zero; zero means end of control list.
//- bulk head register at 28h, read/write, pointer in bits 31:4.
//- bulk list traversal begins at the bulk head pointer.
//- bulk head pointer loads from host comm area during initialisation.
//- control head gives control list start and end-of-list reload value.
`timescale 1ns/1ps
module ohlp_list_ptrs (
    input  wire logic                        clk_sys_i,
    input  wire logic                        arst_n_i,
    input  wire logic [ohlp_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic                        reg_wr_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] controller_config_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] command_status_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] ctl_head_i,
    input  wire logic                        frame_start_i,
    input  wire logic                        desc_served_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] next_desc_i,
    input  wire logic                        end_of_list_i,
    input  wire logic                        comm_area_load_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0] comm_area_bulk_head_i,
    input  wire logic                        bulk_start_i,
    output logic [ohlp_pkg::DATA_W-1:0]      reg_rdata_o,
    output logic                             reg_rvalid_o,
    output logic [ohlp_pkg::DATA_W-1:0]      ctl_current_o,
    output logic                             ctl_pending_o,
    output logic                             ctl_resume_o,
    output logic [ohlp_pkg::DATA_W-1:0]      ctl_resume_ptr_o,
    output logic                             filled_clear_o,
    output logic                             bulk_trav_o,
    output logic [ohlp_pkg::DATA_W-1:0]      bulk_trav_ptr_o
);
    import ohlp_pkg::*;

    logic              ctl_cur_wr;
    logic              bulk_head_wr;
    logic              cle;
    logic              list_filled;
    logic              host_cur_ok;
    ohlp_src_e         cur_src;

    logic [DATA_W-1:0] ctl_cur_d;
    logic [DATA_W-1:0] ctl_cur_q;
    logic              filled_clr_d;
    logic              filled_clr_q;
    logic              pending_d;
    logic [DATA_W-1:0] bulk_head_d;
    logic [DATA_W-1:0] bulk_head_q;
    logic              resume_d;
    logic              resume_q;
    logic [DATA_W-1:0] resume_ptr_d;
    logic [DATA_W-1:0] resume_ptr_q;
    logic              btrav_d;
    logic              btrav_q;
    logic [DATA_W-1:0] btrav_ptr_d;
    logic [DATA_W-1:0] btrav_ptr_q;

    ohlp_reg_port u_reg_port (
        .clk_sys_i      (clk_sys_i),
        .arst_n_i       (arst_n_i),
        .reg_addr_i     (reg_addr_i),
        .reg_wr_i       (reg_wr_i),
        .reg_rd_i       (reg_rd_i),
        .ctl_cur_i      (ctl_cur_q),
        .bulk_head_i    (bulk_head_q),
        .ctl_cur_wr_o   (ctl_cur_wr),
        .bulk_head_wr_o (bulk_head_wr),
        .rdata_o        (reg_rdata_o),
        .rvalid_o       (reg_rvalid_o)
    );

    // control current pointer: source select and next value
    always_comb begin
        cle         = controller_config_i[CLE_BIT];
        list_filled = command_status_i[FILLED_BIT];
        host_cur_ok = ctl_cur_wr && !cle;
        if (host_cur_ok) begin
            cur_src = OHLP_SRC_HOST;
        end else if (end_of_list_i && list_filled) begin
            cur_src = OHLP_SRC_HEAD;
        end else if (end_of_list_i) begin
            cur_src = OHLP_SRC_HOLD;
        end else if (desc_served_i) begin
            cur_src = OHLP_SRC_NEXT;
        end else begin
            cur_src = OHLP_SRC_HOLD;
        end
        filled_clr_d = (cur_src == OHLP_SRC_HEAD);
        unique case (cur_src)
            OHLP_SRC_HOST: ctl_cur_d = reg_wdata_i & PTR_MASK;
            OHLP_SRC_HEAD: ctl_cur_d = ctl_head_i & PTR_MASK;
            OHLP_SRC_NEXT: ctl_cur_d = next_desc_i & PTR_MASK;
            OHLP_SRC_HOLD: ctl_cur_d = ctl_cur_q;
        endcase
        pending_d = (ctl_cur_d != END_OF_LIST);
    end

    // bulk head pointer, frame resume and bulk traversal start
    always_comb begin
        if (comm_area_load_i) begin
            bulk_head_d = comm_area_bulk_head_i & PTR_MASK;
        end else if (bulk_head_wr) begin
            bulk_head_d = reg_wdata_i & PTR_MASK;
        end else begin
            bulk_head_d = bulk_head_q;
        end
        resume_d     = frame_start_i;
        resume_ptr_d = frame_start_i ? ctl_cur_q : resume_ptr_q;
        btrav_d      = bulk_start_i;
        btrav_ptr_d  = bulk_start_i ? bulk_head_q : btrav_ptr_q;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_cur_q    <= CTL_CUR_RST;
            filled_clr_q <= 1'b0;
            bulk_head_q  <= BULK_HEAD_RST;
            resume_q     <= 1'b0;
            resume_ptr_q <= END_OF_LIST;
            btrav_q      <= 1'b0;
            btrav_ptr_q  <= END_OF_LIST;
        end else begin
            ctl_cur_q    <= ctl_cur_d;
            filled_clr_q <= filled_clr_d;
            bulk_head_q  <= bulk_head_d;
            resume_q     <= resume_d;
            resume_ptr_q <= resume_ptr_d;
            btrav_q      <= btrav_d;
            btrav_ptr_q  <= btrav_ptr_d;
        end
    end

    // pending flag registered alongside the pointer
    logic pending_q;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end

    assign ctl_current_o    = ctl_cur_q;
    assign ctl_pending_o    = pending_q;
    assign filled_clear_o   = filled_clr_q;
    assign ctl_resume_o     = resume_q;
    assign ctl_resume_ptr_o = resume_ptr_q;
    assign bulk_trav_o      = btrav_q;
    assign bulk_trav_ptr_o  = btrav_ptr_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_cur_advance: assert property (
        desc_served_i && !end_of_list_i && !host_cur_ok
        |=> ctl_cur_q == ($past(next_desc_i) & PTR_MASK))
        else $error("current pointer did not advance");

    a_eol_reload: assert property (
        end_of_list_i && list_filled && !host_cur_ok
        |=> ctl_cur_q == ($past(ctl_head_i) & PTR_MASK) && filled_clear_o)
        else $error("end of list reload missing");

    a_eol_hold: assert property (
        end_of_list_i && !list_filled && !host_cur_ok |=> $stable(ctl_cur_q)
        && !filled_clear_o)
        else $error("pointer changed at end with flag clear");

    a_host_blocked: assert property (
        ctl_cur_wr && cle && !end_of_list_i && !desc_served_i
        |=> $stable(ctl_cur_q))
        else $error("host write taken while list enabled");

    a_host_first: assert property (
        host_cur_ok |=> !filled_clear_o)
        else $error("reload request raised over a host write");

    a_host_write: assert property (
        ctl_cur_wr && !cle |=> ctl_cur_q == ($past(reg_wdata_i) & PTR_MASK))
        else $error("host write to current pointer lost");

    a_read_live: assert property (
        reg_rd_i && reg_addr_i == CTL_CUR_OFS
        |=> reg_rvalid_o && reg_rdata_o == $past(ctl_cur_q))
        else $error("current pointer read not live");

    a_rvalid_pulse: assert property (
        !reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without a read request");

    a_rsvd_zero: assert property (
        ctl_cur_q[RSVD_MSB:0] == '0 && bulk_head_q[RSVD_MSB:0] == '0)
        else $error("reserved bits not zero");

    a_bulk_init: assert property (
        comm_area_load_i
        |=> bulk_head_q == ($past(comm_area_bulk_head_i) & PTR_MASK))
        else $error("bulk head not loaded at init");

    a_bulk_trav: assert property (
        bulk_start_i |=> bulk_trav_o && bulk_trav_ptr_o == $past(bulk_head_q))
        else $error("bulk traversal not from head");

    a_frame_resume: assert property (
        frame_start_i |=> ctl_resume_o ##0 ctl_resume_ptr_o == $past(ctl_cur_q))
        else $error("frame did not resume at current pointer");

    a_pending_zero: assert property (
        ctl_pending_o == (ctl_cur_q != END_OF_LIST))
        else $error("pending flag disagrees with pointer");

    c_reload: cover property (end_of_list_i && list_filled ##1 filled_clear_o);
    c_advance: cover property (desc_served_i ##1 desc_served_i);
    c_host_wr: cover property (ctl_cur_wr && !cle);
    c_bulk: cover property (comm_area_load_i ##[1:4] bulk_start_i);
    c_resume: cover property (frame_start_i ##1 ctl_resume_o);
endmodule : ohlp_list_ptrs

// >>> inc/ohlp_pkg.sv
package ohlp_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam logic [7:0]  CTL_CUR_OFS   = 8'h24;
    localparam logic [7:0]  BULK_HEAD_OFS = 8'h28;
    localparam logic [31:0] CTL_CUR_RST   = 32'h0000_0000;
    localparam logic [31:0] BULK_HEAD_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_MASK      = 32'hFFFF_FFF0;
    localparam logic [31:0] END_OF_LIST   = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;
    localparam int unsigned PTR_LSB       = 4;
    localparam int unsigned RSVD_MSB      = 3;
    localparam int unsigned FILLED_BIT    = 1;
    localparam int unsigned CLE_BIT       = 4;

    typedef enum logic [1:0] {
        OHLP_SRC_HOLD,
        OHLP_SRC_NEXT,
        OHLP_SRC_HEAD,
        OHLP_SRC_HOST
    } ohlp_src_e;
endpackage : ohlp_pkg

// >>> core/ohlp_reg_port.sv
`timescale 1ns/1ps
module ohlp_reg_port (
    input  wire logic                         clk_sys_i,
    input  wire logic                         arst_n_i,
    input  wire logic [ohlp_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0]  ctl_cur_i,
    input  wire logic [ohlp_pkg::DATA_W-1:0]  bulk_head_i,
    output logic                              ctl_cur_wr_o,
    output logic                              bulk_head_wr_o,
    output logic [ohlp_pkg::DATA_W-1:0]       rdata_o,
    output logic                              rvalid_o
);
    import ohlp_pkg::*;

    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_d;
    logic              rvalid_q;

    // write strobes per register
    always_comb begin
        ctl_cur_wr_o   = reg_wr_i && (reg_addr_i == CTL_CUR_OFS);
        bulk_head_wr_o = reg_wr_i && (reg_addr_i == BULK_HEAD_OFS);
    end

    // read samples the live register value, unmapped reads return zero
    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = rdata_q;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                CTL_CUR_OFS:   rdata_d = ctl_cur_i;
                BULK_HEAD_OFS: rdata_d = bulk_head_i;
                default:       rdata_d = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q  <= RD_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata_o  = rdata_q;
    assign rvalid_o = rvalid_q;
endmodule : ohlp_reg_port

// >>> dv/test_ohci_control_bulk_list_pointers.sv
`timescale 1ns/1ps
module test_ohci_control_bulk_list_pointers;
    import ohlp_pkg::*;
    logic              clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i;
    logic              frame_start_i, desc_served_i, end_of_list_i;
    logic              comm_area_load_i, bulk_start_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [31:0]       reg_wdata_i, controller_config_i, command_status_i;
    logic [31:0]       ctl_head_i, next_desc_i, comm_area_bulk_head_i;
    logic [31:0]       reg_rdata_o, ctl_current_o, ctl_resume_ptr_o;
    logic [31:0]       bulk_trav_ptr_o;
    logic              reg_rvalid_o, ctl_pending_o, ctl_resume_o;
    logic              filled_clear_o, bulk_trav_o;
    int                errors, cmp_count;
    int unsigned       op;
    logic [31:0]       m_cur, m_bh, m_rd, m_rptr, m_tptr;
    logic              m_rv, m_res, m_clr, m_trav, m_wr;

    ohlp_list_ptrs dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .controller_config_i(controller_config_i),
        .command_status_i(command_status_i), .ctl_head_i(ctl_head_i),
        .frame_start_i(frame_start_i), .desc_served_i(desc_served_i),
        .next_desc_i(next_desc_i), .end_of_list_i(end_of_list_i),
        .comm_area_load_i(comm_area_load_i),
        .comm_area_bulk_head_i(comm_area_bulk_head_i),
        .bulk_start_i(bulk_start_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .ctl_current_o(ctl_current_o),
        .ctl_pending_o(ctl_pending_o), .ctl_resume_o(ctl_resume_o),
        .ctl_resume_ptr_o(ctl_resume_ptr_o), .filled_clear_o(filled_clear_o),
        .bulk_trav_o(bulk_trav_o), .bulk_trav_ptr_o(bulk_trav_ptr_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task results;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] rnd();
        return ($urandom_range(0, 3) == 0) ? 32'h0000_0000 : $urandom;
    endfunction : rnd

    task drive_idle;
        {reg_wr_i, reg_rd_i, frame_start_i, desc_served_i} <= 4'h0;
        {end_of_list_i, comm_area_load_i, bulk_start_i} <= 3'h0;
        {reg_addr_i, reg_wdata_i, controller_config_i} <= '0;
        {command_status_i, ctl_head_i, next_desc_i} <= '0;
        comm_area_bulk_head_i <= '0;
        {m_cur, m_bh, m_rd, m_rptr, m_tptr} = '0;
        {m_rv, m_res, m_clr, m_trav} = 4'h0;
    endtask : drive_idle

    task drive_rand;
        op = $urandom_range(0, 7);
        reg_wr_i <= op inside {1, 2, 3}
                    || (op inside {4, 5, 6} && $urandom_range(0, 1));
        case (op)
            1, 4, 5: reg_addr_i <= CTL_CUR_OFS;
            2, 6: reg_addr_i <= BULK_HEAD_OFS;
            3: reg_addr_i <= 8'h30;
            default: reg_addr_i <= 8'h24 + 8'h04 * $urandom_range(0, 3);
        endcase
        reg_rd_i <= $urandom_range(0, 1);
        reg_wdata_i <= rnd();
        controller_config_i <= $urandom;
        command_status_i <= $urandom;
        ctl_head_i <= rnd();
        next_desc_i <= rnd();
        comm_area_bulk_head_i <= rnd();
        frame_start_i <= ($urandom_range(0, 3) == 0);
        desc_served_i <= (op == 4);
        end_of_list_i <= (op == 5);
        comm_area_load_i <= (op == 6);
        bulk_start_i <= (op == 7);
    endtask : drive_rand

    task model_step;
        if (reg_rd_i) begin
            m_rd = (reg_addr_i == CTL_CUR_OFS) ? m_cur :
                   (reg_addr_i == BULK_HEAD_OFS) ? m_bh : RD_UNMAPPED;
        end
        if (frame_start_i) m_rptr = m_cur;
        if (bulk_start_i) m_tptr = m_bh;
        m_rv = reg_rd_i;
        m_res = frame_start_i;
        m_trav = bulk_start_i;
        m_wr = reg_wr_i && reg_addr_i == CTL_CUR_OFS
               && !controller_config_i[CLE_BIT];
        m_clr = end_of_list_i && command_status_i[FILLED_BIT] && !m_wr;
        if (m_wr) begin
            m_cur = reg_wdata_i & PTR_MASK;
        end else if (m_clr) begin
            m_cur = ctl_head_i & PTR_MASK;
        end else if (desc_served_i && !end_of_list_i) begin
            m_cur = next_desc_i & PTR_MASK;
        end
        if (comm_area_load_i) m_bh = comm_area_bulk_head_i & PTR_MASK;
        else if (reg_wr_i && reg_addr_i == BULK_HEAD_OFS) begin
            m_bh = reg_wdata_i & PTR_MASK;
        end
    endtask : model_step

    task check_all;
        chk("rdata", reg_rdata_o, m_rd);
        chk("rvalid", reg_rvalid_o, m_rv);
        chk("current", ctl_current_o, m_cur);
        chk("current_wr", ctl_current_o, m_cur);
        chk("pending", ctl_pending_o, m_cur != END_OF_LIST);
        chk("resume", ctl_resume_o, m_res);
        chk("resume_ptr", ctl_resume_ptr_o, m_rptr);
        chk("filled_clear", filled_clear_o, m_clr);
        chk("trav", bulk_trav_o, m_trav);
        chk("trav_ptr", bulk_trav_ptr_o, m_tptr);
    endtask : check_all

    task run_cycles(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            model_step();
            drive_rand();
            #1;
            check_all();
        end
    endtask : run_cycles

    initial begin
        errors = 0;
        cmp_count = 0;
        arst_n_i = 1'b0;
        drive_idle();
        op = $urandom(32'h869c_f767);
        repeat (4) @(posedge clk_sys_i);
        #1;
        check_all();
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        run_cycles(2000);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        drive_idle();
        repeat (3) @(posedge clk_sys_i);
        #1;
        check_all();
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        run_cycles(2000);
        results();
    end

    initial begin
        #400000;
        errors++;
        results();
    end
endmodule : test_ohci_control_bulk_list_pointers
